// ===== verilog/iebdc_pkg.sv
/*
 * Constants, operation codes, field positions and register map of the
 * branch, call, watchdog-clear and file-operation execution unit.
 * Assumes the core issues decoded operations and owns the file registers,
 * the accumulator, the status register and the return stack.
 */
package iebdc_pkg;

    localparam int PC_W     = 11;
    localparam int DATA_W   = 8;
    localparam int FILE_AW  = 5;
    localparam int LIT_W    = 9;
    localparam int OP_W     = 3;
    localparam int WB_AW    = 8;
    localparam int WB_DW    = 32;

    // Operation codes on the issue port
    localparam logic [2:0] OP_NONE  = 3'h0;
    localparam logic [2:0] OP_CALL  = 3'h1;
    localparam logic [2:0] OP_BRANCH = 3'h2;
    localparam logic [2:0] OP_WCLR  = 3'h3;
    localparam logic [2:0] OP_FZERO = 3'h4;
    localparam logic [2:0] OP_FINV  = 3'h5;
    localparam logic [2:0] OP_FDEC  = 3'h6;
    localparam logic [2:0] OP_FDSZ  = 3'h7;

    // Field positions
    localparam int STAT_PAGE_HI = 6;
    localparam int STAT_PAGE_LO = 5;
    localparam int CALL_LIT_HI  = 7;

    // Register map
    localparam logic [7:0] ADR_CTRL  = 8'h00;
    localparam logic [7:0] ADR_FLAGS = 8'h04;
    localparam int CTRL_PRESC_BIT  = 0;
    localparam int FLAGS_EXPIRY_BIT = 0;
    localparam int FLAGS_SLEEP_BIT  = 1;

    // Reset values
    localparam logic RST_PRESC_WDT = 1'b0;
    localparam logic RST_FLAG_N    = 1'b1;

    typedef enum logic {ST_ISSUE, ST_BUBBLE} iebdc_state_t;

endpackage

// ===== verilog/iebdc_exec.sv
/*
 * Execution unit for call, branch, watchdog clear and the clear,
 * complement, decrement and decrement-skip file operations, with a
 * classic Wishbone slave for prescaler assignment and flag readback.
 * Assumes the core presents the current program address, the status byte
 * and the read data of the addressed file register combinationally.
 */
// The implementer's own choices: the address map and register access over Wishbone.
module iebdc_exec (
    // Clock and reset
    input  wire logic                           clk,
    input  wire logic                           srst,
    // Operation issue
    input  wire logic                           instrValid,
    input  wire logic [iebdc_pkg::OP_W-1:0]     instrOp,
    input  wire logic [iebdc_pkg::LIT_W-1:0]    instrLit,
    input  wire logic [iebdc_pkg::FILE_AW-1:0]  instrFile,
    input  wire logic                           instrDest,
    output logic                                instrReady,
    // Core state
    input  wire logic [iebdc_pkg::PC_W-1:0]     pcCur,
    input  wire logic [iebdc_pkg::DATA_W-1:0]   statusIn,
    // Program counter and return stack
    output logic                                pcLoad,
    output logic [iebdc_pkg::PC_W-1:0]          pcLoadVal,
    output logic                                stackPush,
    output logic [iebdc_pkg::PC_W-1:0]          stackData,
    output logic                                flushFetch,
    // File register and accumulator
    output logic [iebdc_pkg::FILE_AW-1:0]       fileRdAddr,
    input  wire logic [iebdc_pkg::DATA_W-1:0]   fileRdData,
    output logic                                fileWe,
    output logic [iebdc_pkg::FILE_AW-1:0]       fileWrAddr,
    output logic [iebdc_pkg::DATA_W-1:0]        fileWrData,
    output logic                                accWe,
    output logic [iebdc_pkg::DATA_W-1:0]        accData,
    // Zero flag update
    output logic                                zeroWe,
    output logic                                zeroVal,
    // Watchdog
    input  wire logic                           wdtTimeout,
    input  wire logic                           sleepEnter,
    output logic                                wdtClear,
    output logic                                prescClear,
    output logic                                expiryFlagN,
    output logic                                sleepFlagN,
    // Wishbone slave
    input  wire logic                           cyc_i,
    input  wire logic                           stb_i,
    input  wire logic                           we_i,
    input  wire logic [iebdc_pkg::WB_AW-1:0]    adr_i,
    input  wire logic [3:0]                     sel_i,
    input  wire logic [iebdc_pkg::WB_DW-1:0]    dat_i,
    output logic [iebdc_pkg::WB_DW-1:0]         dat_o,
    output logic                                ack_o
);

    function automatic logic isNull(input logic [iebdc_pkg::DATA_W-1:0] v);
        isNull = (v == {iebdc_pkg::DATA_W{1'b0}});
    endfunction

    iebdc_pkg::iebdc_state_t state_r;
    iebdc_pkg::iebdc_state_t state_nxt;

    logic                               pcLoad_r;
    logic [iebdc_pkg::PC_W-1:0]         pcLoadVal_r;
    logic                               stackPush_r;
    logic [iebdc_pkg::PC_W-1:0]         stackData_r;
    logic                               flush_r;
    logic                               fileWe_r;
    logic [iebdc_pkg::FILE_AW-1:0]      fileWrAddr_r;
    logic [iebdc_pkg::DATA_W-1:0]       res_r;
    logic                               accWe_r;
    logic                               zeroWe_r;
    logic                               zeroVal_r;
    logic                               wdtClear_r;
    logic                               prescClear_r;
    logic                               expiry_r;
    logic                               sleep_r;
    logic                               prescToWdt_r;
    logic                               ack_r;
    logic [iebdc_pkg::WB_DW-1:0]        dat_r;

    // Issue decode
    wire take    = instrValid & instrReady;
    wire isCall  = take & (instrOp == iebdc_pkg::OP_CALL);
    wire isBranch = take & (instrOp == iebdc_pkg::OP_BRANCH);
    wire isWclr  = take & (instrOp == iebdc_pkg::OP_WCLR);
    wire isZero  = take & (instrOp == iebdc_pkg::OP_FZERO);
    wire isInv   = take & (instrOp == iebdc_pkg::OP_FINV);
    wire isDec   = take & (instrOp == iebdc_pkg::OP_FDEC);
    wire isDsz   = take & (instrOp == iebdc_pkg::OP_FDSZ);
    wire isRmw   = isInv | isDec | isDsz;

    wire [1:0] page = statusIn[iebdc_pkg::STAT_PAGE_HI:iebdc_pkg::STAT_PAGE_LO];
    wire [iebdc_pkg::DATA_W-1:0] decRes = fileRdData - 8'h01;
    wire [iebdc_pkg::DATA_W-1:0] rmwRes = isInv ? ~fileRdData : decRes;
    wire [iebdc_pkg::PC_W-1:0] callTgt = {page, 1'b0, instrLit[iebdc_pkg::CALL_LIT_HI:0]};
    wire [iebdc_pkg::PC_W-1:0] branchTgt = {page, instrLit};
    wire skipNow = isDsz & isNull(decRes);
    wire twoCyc  = isCall | isBranch | skipNow;

    // Second cycle of a two-cycle operation is a bubble: nothing is taken
    assign instrReady = (state_r == iebdc_pkg::ST_ISSUE);

    always_comb begin
        case (state_r)
            iebdc_pkg::ST_ISSUE: begin
                state_nxt = twoCyc ? iebdc_pkg::ST_BUBBLE : iebdc_pkg::ST_ISSUE;
            end
            iebdc_pkg::ST_BUBBLE: begin
                state_nxt = iebdc_pkg::ST_ISSUE;
            end
            default: begin
                state_nxt = iebdc_pkg::ST_ISSUE;
            end
        endcase
    end
    assign fileRdAddr = instrFile;

    always_ff @(posedge clk) begin
        if (srst) begin
            state_r <= iebdc_pkg::ST_ISSUE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Program counter and stack; push pulses with the load on a call only, push carries the next address
    always_ff @(posedge clk) begin
        if (srst) begin
            pcLoad_r    <= 1'b0;
            pcLoadVal_r <= '0;
            stackPush_r <= 1'b0;
            stackData_r <= '0;
            flush_r     <= 1'b0;
        end else begin
            pcLoad_r    <= isCall | isBranch;
            pcLoadVal_r <= isCall ? callTgt : branchTgt;
            stackPush_r <= isCall;
            stackData_r <= pcCur + 11'h001;
            flush_r     <= twoCyc;
        end
    end

    // File results; call, branch and decrement-skip never touch the zero flag
    always_ff @(posedge clk) begin
        if (srst) begin
            fileWe_r     <= 1'b0;
            fileWrAddr_r <= '0;
            res_r        <= '0;
            accWe_r      <= 1'b0;
            zeroWe_r     <= 1'b0;
            zeroVal_r    <= 1'b0;
        end else begin
            fileWe_r     <= isZero | (isRmw & instrDest);
            fileWrAddr_r <= instrFile;
            res_r        <= isZero ? 8'h00 : rmwRes;
            accWe_r      <= isRmw & ~instrDest;
            zeroWe_r     <= isZero | isInv | isDec;
            zeroVal_r    <= isZero | isNull(rmwRes);
        end
    end

    // Watchdog clear; a hardware timeout or sleep in the same cycle wins
    always_ff @(posedge clk) begin
        if (srst) begin
            wdtClear_r   <= 1'b0;
            prescClear_r <= 1'b0;
            expiry_r     <= iebdc_pkg::RST_FLAG_N;
            sleep_r      <= iebdc_pkg::RST_FLAG_N;
        end else begin
            wdtClear_r   <= isWclr;
            prescClear_r <= isWclr & prescToWdt_r;
            if (wdtTimeout) begin
                expiry_r <= 1'b0;
            end else if (isWclr) begin
                expiry_r <= 1'b1;
            end
            if (sleepEnter) begin
                sleep_r <= 1'b0;
            end else if (isWclr) begin
                sleep_r <= 1'b1;
            end
        end
    end

    // Wishbone slave: one wait state, unmapped reads return zero
    wire wbReq   = cyc_i & stb_i & ~ack_r;
    wire hitCtrl = (adr_i == iebdc_pkg::ADR_CTRL);
    wire hitFlg  = (adr_i == iebdc_pkg::ADR_FLAGS);
    // Write lands on the acknowledging edge, so an abandoned request never writes
    wire wbWrite = cyc_i & stb_i & ack_r & we_i & hitCtrl & sel_i[0];
    wire [iebdc_pkg::WB_DW-1:0] rdMux =
        hitCtrl ? {31'h0, prescToWdt_r} :
        hitFlg  ? {30'h0, sleep_r, expiry_r} : 32'h0;

    always_ff @(posedge clk) begin
        if (srst) begin
            ack_r        <= 1'b0;
            dat_r        <= '0;
            prescToWdt_r <= iebdc_pkg::RST_PRESC_WDT;
        end else begin
            ack_r <= wbReq;
            dat_r <= wbReq ? rdMux : 32'h0;
            if (wbWrite) begin
                prescToWdt_r <= dat_i[iebdc_pkg::CTRL_PRESC_BIT];
            end
        end
    end

    assign pcLoad      = pcLoad_r;
    assign pcLoadVal   = pcLoadVal_r;
    assign stackPush   = stackPush_r;
    assign stackData   = stackData_r;
    assign flushFetch  = flush_r;
    assign fileWe      = fileWe_r;
    assign fileWrAddr  = fileWrAddr_r;
    assign fileWrData  = res_r;
    assign accWe       = accWe_r;
    assign accData     = res_r;
    assign zeroWe      = zeroWe_r;
    assign zeroVal     = zeroVal_r;
    assign wdtClear    = wdtClear_r;
    assign prescClear  = prescClear_r;
    assign expiryFlagN = expiry_r;
    assign sleepFlagN  = sleep_r;
    assign dat_o       = dat_r;
    assign ack_o       = ack_r;

    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    sequence bubbleThenIssue;
        (!instrReady && !zeroWe) ##1 instrReady;
    endsequence

    sequence loadedThisCycle;
        pcLoad && !zeroWe && !fileWe && !accWe;
    endsequence

    call_push_a: assert property (
        isCall |=> stackPush && stackData == $past(pcCur) + 11'h001)
        else $error("call did not push next address");

    call_low_a: assert property (
        isCall |=> loadedThisCycle and pcLoadVal[7:0] == $past(instrLit[7:0]))
        else $error("call low address wrong");

    call_page_a: assert property (
        isCall |=> pcLoadVal[10:9] == $past(page) && !pcLoadVal[8])
        else $error("call page bits wrong");

    call_two_a: assert property (
        isCall |=> bubbleThenIssue)
        else $error("call not two cycles");

    wdt_clear_a: assert property (
        isWclr |=> wdtClear ##1 (wdtClear == $past(isWclr)))
        else $error("watchdog clear pulse wrong");

    presc_clear_a: assert property (
        isWclr |=> prescClear == $past(prescToWdt_r))
        else $error("prescaler clear ignores assignment");

    flags_set_a: assert property (
        isWclr && !wdtTimeout && !sleepEnter |=> expiryFlagN && sleepFlagN)
        else $error("flags not set by watchdog clear");

    fzero_a: assert property (
        isZero |=> fileWe && fileWrData == 8'h00 && zeroWe && zeroVal
                   && fileWrAddr == $past(instrFile))
        else $error("file zero wrong");

    dest_sel_a: assert property (
        isRmw |=> fileWe == $past(instrDest) && accWe == !$past(instrDest))
        else $error("destination select wrong");

    finv_a: assert property (
        isInv |=> accData == ~$past(fileRdData) && zeroWe
                  && zeroVal == ($past(fileRdData) == 8'hFF))
        else $error("invert result wrong");

    fdec_a: assert property (
        isDec |=> accData == $past(fileRdData) - 8'h01 && zeroWe
                  && zeroVal == ($past(fileRdData) == 8'h01))
        else $error("decrement result wrong");

    fdsz_flags_a: assert property (
        isDsz |=> !zeroWe && accData == $past(fileRdData) - 8'h01)
        else $error("decrement-skip result or flags wrong");

    skip_bubble_a: assert property (
        skipNow |=> flushFetch && !pcLoad ##0 bubbleThenIssue)
        else $error("zero result did not skip");

    branch_addr_a: assert property (
        isBranch |=> loadedThisCycle and pcLoadVal[8:0] == $past(instrLit))
        else $error("branch low address wrong");

    branch_page_a: assert property (
        isBranch |=> pcLoadVal[10:9] == $past(page) && !stackPush)
        else $error("branch page bits wrong");

    branch_two_a: assert property (
        isBranch |=> flushFetch ##0 bubbleThenIssue)
        else $error("branch not two cycles");

    single_cyc_a: assert property (
        take && !twoCyc |=> instrReady && !flushFetch)
        else $error("single-cycle operation stalled");

endmodule

// ===== sim/instr_exec_branch_dec_clear_tb.sv
/*
 * Self-checking testbench for the branch, call, watchdog-clear and file
 * operation execution unit: issue-port tasks and Wishbone register tasks.
 * Assumes the unit answers one cycle after taking an operation, that the
 * register bus answers after one wait state, and that design checks run.
 */
module instr_exec_branch_dec_clear_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // Clock and reset
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    // Issue port and core state
    logic        instrValid = 1'b0;
    logic [2:0]  instrOp = 3'h0;
    logic [8:0]  instrLit = 9'h000;
    logic [4:0]  instrFile = 5'h00;
    logic        instrDest = 1'b0;
    logic        instrReady;
    logic [10:0] pcCur = 11'h7FF;
    logic [7:0]  statusIn = 8'h00;
    logic [7:0]  fileRdData = 8'h00;
    logic        wdtTimeout = 1'b0;
    logic        sleepEnter = 1'b0;
    // Wishbone
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i = 1'b0;
    logic [7:0]  adr_i = 8'h00;
    logic [3:0]  sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0000_0000;
    logic [31:0] dat_o;
    logic        ack_o;
    // Outputs
    logic        pcLoad, stackPush, flushFetch, fileWe, accWe, zeroWe, zeroVal;
    logic        wdtClear, prescClear, expiryFlagN, sleepFlagN;
    logic [10:0] pcLoadVal, stackData;
    logic [4:0]  fileRdAddr, fileWrAddr;
    logic [7:0]  fileWrData, accData;
    logic [31:0] rdWord;
    int          mismatches = 0;
    int          checkCount = 0;

    always #20 clk = ~clk;

    iebdc_exec i_iebdc_exec (
        .clk(clk), .srst(srst), .instrValid(instrValid), .instrOp(instrOp),
        .instrLit(instrLit), .instrFile(instrFile), .instrDest(instrDest),
        .instrReady(instrReady), .pcCur(pcCur), .statusIn(statusIn), .pcLoad(pcLoad),
        .pcLoadVal(pcLoadVal), .stackPush(stackPush), .stackData(stackData),
        .flushFetch(flushFetch), .fileRdAddr(fileRdAddr), .fileRdData(fileRdData),
        .fileWe(fileWe), .fileWrAddr(fileWrAddr), .fileWrData(fileWrData),
        .accWe(accWe), .accData(accData), .zeroWe(zeroWe), .zeroVal(zeroVal),
        .wdtTimeout(wdtTimeout), .sleepEnter(sleepEnter), .wdtClear(wdtClear),
        .prescClear(prescClear), .expiryFlagN(expiryFlagN), .sleepFlagN(sleepFlagN),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o)
    );

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checkCount++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", checkCount, mismatches);
        if (mismatches == 0 && checkCount > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Pulse vector: pcLoad stackPush flushFetch fileWe accWe zeroWe wdtClear prescClear
    task automatic runOp(input logic [2:0] o, input logic [8:0] lit, input logic [4:0] f,
                         input logic d, input logic [7:0] st, input logic [7:0] rd,
                         input logic [7:0] p, input logic [10:0] pcv, input logic [7:0] dv,
                         input logic zv, input logic rdy);
        logic [7:0]  seen;
        logic [10:0] ret;
        ret = pcCur + 11'h001;
        @(posedge clk);
        instrValid <= 1'b1;
        instrOp    <= o;
        instrLit   <= lit;
        instrFile  <= f;
        instrDest  <= d;
        statusIn   <= st;
        fileRdData <= rd;
        @(posedge clk);
        check("instrReady at issue", 1'b1, instrReady);
        check("fileRdAddr", f, fileRdAddr);
        instrValid <= 1'b0;
        // Registered answers are read at the edge that closes the answer cycle
        @(posedge clk);
        seen = {pcLoad, stackPush, flushFetch, fileWe, accWe, zeroWe, wdtClear, prescClear};
        check("pulses", p, seen);
        check("instrReady after", rdy, instrReady);
        if (p[7]) check("pcLoadVal", pcv, pcLoadVal);
        if (p[6]) check("stackData", ret, stackData);
        if (p[4]) check("fileWrAddr", f, fileWrAddr);
        if (p[4]) check("fileWrData", dv, fileWrData);
        if (p[3]) check("accData", dv, accData);
        if (p[2]) check("zeroVal", zv, zeroVal);
    endtask

    task automatic wbCycle(input logic [7:0] a, input logic w, input logic [31:0] wd,
                           output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        sel_i <= 4'hF;
        dat_i <= wd;
        do begin
            @(posedge clk);
            n++;
        end while (ack_o !== 1'b1);
        // Only the bench timeout ends a stuck wait; the latency itself is checked
        rd = dat_o;
        check("ack_o wait", 32'h0000_0002, n);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
    endtask

    task automatic wbRead(input logic [7:0] a, input logic [31:0] exp);
        wbCycle(a, 1'b0, 32'h0000_0000, rdWord);
        check("register read", exp, rdWord);
    endtask

    initial begin
        // Timeout well above the fewer than 100 cycles the tests need
        #(3000 * 40);
        mismatches++;
        complete_run();
    end

    initial begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        wbRead(8'h00, 32'h0000_0000);
        wbRead(8'h04, 32'h0000_0003);
        $display("test reset done");
        // Wrapping return address and a literal bit 8 that must not leak
        runOp(3'h1, 9'h1AB, 5'h00, 1'b0, 8'hE0, 8'h00, 8'hE0, 11'h6AB, 8'h00, 1'b0, 1'b0);
        runOp(3'h2, 9'h155, 5'h00, 1'b0, 8'hA0, 8'h00, 8'hA0, 11'h355, 8'h00, 1'b0, 1'b0);
        runOp(3'h2, 9'h1FF, 5'h00, 1'b0, 8'h40, 8'h00, 8'hA0, 11'h5FF, 8'h00, 1'b0, 1'b0);
        runOp(3'h0, 9'h1FF, 5'h00, 1'b1, 8'h60, 8'h00, 8'h00, 11'h000, 8'h00, 1'b0, 1'b1);
        $display("test call and branch done");
        @(posedge clk);
        wdtTimeout <= 1'b1;
        sleepEnter <= 1'b1;
        @(posedge clk);
        wdtTimeout <= 1'b0;
        sleepEnter <= 1'b0;
        wbRead(8'h04, 32'h0000_0000);
        runOp(3'h3, 9'h000, 5'h00, 1'b0, 8'h00, 8'h00, 8'h02, 11'h000, 8'h00, 1'b0, 1'b1);
        check("flags after clear", 2'b11, {expiryFlagN, sleepFlagN});
        wbRead(8'h04, 32'h0000_0003);
        wbCycle(8'h00, 1'b1, 32'h0000_0001, rdWord);
        wbRead(8'h00, 32'h0000_0001);
        runOp(3'h3, 9'h000, 5'h00, 1'b0, 8'h00, 8'h00, 8'h03, 11'h000, 8'h00, 1'b0, 1'b1);
        wbCycle(8'h00, 1'b1, 32'h0000_0000, rdWord);
        // Flags are read-only and holes read as zero
        wbCycle(8'h04, 1'b1, 32'h0000_0000, rdWord);
        wbRead(8'h04, 32'h0000_0003);
        wbRead(8'h08, 32'h0000_0000);
        $display("test watchdog clear done");
        runOp(3'h4, 9'h000, 5'h1F, 1'b0, 8'h00, 8'h5A, 8'h14, 11'h000, 8'h00, 1'b1, 1'b1);
        runOp(3'h5, 9'h000, 5'h03, 1'b0, 8'h00, 8'hFF, 8'h0C, 11'h000, 8'h00, 1'b1, 1'b1);
        runOp(3'h5, 9'h000, 5'h04, 1'b1, 8'h00, 8'h0F, 8'h14, 11'h000, 8'hF0, 1'b0, 1'b1);
        runOp(3'h6, 9'h000, 5'h05, 1'b1, 8'h00, 8'h00, 8'h14, 11'h000, 8'hFF, 1'b0, 1'b1);
        runOp(3'h6, 9'h000, 5'h06, 1'b0, 8'h00, 8'h01, 8'h0C, 11'h000, 8'h00, 1'b1, 1'b1);
        $display("test file operations done");
        runOp(3'h7, 9'h000, 5'h07, 1'b1, 8'h00, 8'h01, 8'h30, 11'h000, 8'h00, 1'b0, 1'b0);
        runOp(3'h7, 9'h000, 5'h08, 1'b0, 8'h00, 8'h00, 8'h08, 11'h000, 8'hFF, 1'b0, 1'b1);
        $display("test decrement skip done");
        complete_run();
    end
endmodule
